/* File: fsp_device.sv */
// Operation
// - channel A fast serial needs channel B
// - channel A may run other mode
// - all serial pins on channel B
// - mode 0x10 freezes, 0x0 releases
// - partner supplies clock for transmit
// - transmit starts with one low bit
// - no transmit start while receiving
// - transmit eight data bits LSB first
// - last transmit bit names source channel
// - partner stalls clock if unable
// - partner starts sending only while clear high
// - clear drops at edge after start
// - receive eight bits LSB then target
// - route by target, fall back otherwise
// - no fast serial channel, port disabled
// - clear stays low until byte taken
// - simultaneous starts: drop transmit, receive
// - one frame layout both directions
// - half duplex, partner clock controls timing
// - pins change only on link clock, except that reset, freeze or disable forces data idle and clear low at once
`timescale 1ns/1ns
module fsp_device
   import fsp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // link pins
   fsp_link_if.device link,
   // configuration
   input wire logic cfg_fast_a,
   input wire logic cfg_fast_b,
   input wire logic mode_valid,
   input wire logic [7:0] mode_value,
   // port status
   output logic port_enabled,
   output logic chan_b_pins_serial,
   output logic chan_a_serial,
   // transmit stream from channels
   input wire logic tx_a_valid,
   input wire logic [DATA_W-1:0] tx_a_data,
   output logic tx_a_ready,
   input wire logic tx_b_valid,
   input wire logic [DATA_W-1:0] tx_b_data,
   output logic tx_b_ready,
   // receive stream to channels
   output logic rx_a_valid,
   output logic rx_b_valid,
   output logic [DATA_W-1:0] rx_data,
   input wire logic rx_a_ready,
   input wire logic rx_b_ready
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RX = 2'b01,
      ST_HOLD = 2'b11,
      ST_TX = 2'b10
   } state_e;

   state_e state;
   logic frozen;
   logic fast_a;
   logic fast_b;
   logic active;
   logic sclk_rise;
   logic sdi;
   logic [3:0] bit_cnt;
   logic [FRAME_BITS-1:0] shreg;
   logic tx_sel;
   logic tx_req;
   logic rx_target_channel_bit;
   logic out_bit;
   logic cts;
   logic rx_take;
   logic tx_abandon;

   fsp_edge_sync u_clk_sync (
      .clk(clk),
      .resetn(resetn),
      .async_in(link.external_shift_clock),
      .level(),
      .rise(sclk_rise),
      .fall()
   );

   fsp_edge_sync u_din_sync (
      .clk(clk),
      .resetn(resetn),
      .async_in(link.serial_in_line),
      .level(sdi),
      .rise(),
      .fall()
   );

   assign fast_b = cfg_fast_b;
   assign fast_a = cfg_fast_a & cfg_fast_b;
   assign port_enabled = fast_a | fast_b;
   assign chan_b_pins_serial = port_enabled;
   assign chan_a_serial = fast_a;
   assign active = port_enabled & ~frozen;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         frozen <= 1'b0;
      end else if (mode_valid && mode_value == MODE_FREEZE) begin
         frozen <= 1'b1;
      end else if (mode_valid && mode_value == MODE_RELEASE) begin
         frozen <= 1'b0;
      end
   end

   // channel B wins when both channels hold a byte
   assign tx_req = (fast_b & tx_b_valid) | (fast_a & tx_a_valid);

   // sequencing advances on link clock rising edges, except that a taken byte leaves hold at once
   always_ff @(posedge clk) begin
      if (!resetn || !active) begin
         state <= ST_IDLE;
         bit_cnt <= BIT_CNT_ZERO;
         shreg <= '0;
         tx_sel <= CHAN_B;
         rx_target_channel_bit <= CHAN_B;
      end else if (sclk_rise) begin
         unique case (state)
            ST_IDLE: begin
               bit_cnt <= BIT_CNT_ZERO;
               if (sdi == START_LEVEL) begin
                  state <= ST_RX;
               end else if (tx_req) begin
                  state <= ST_TX;
                  tx_sel <= (fast_b & tx_b_valid) ? CHAN_B : CHAN_A;
               end
            end
            ST_RX: begin
               shreg <= {sdi, shreg[FRAME_BITS-1:1]};
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == BIT_CNT_LAST - 4'h1) begin
                  state <= ST_HOLD;
                  rx_target_channel_bit <= sdi;
               end
            end
            ST_HOLD: begin
               // a take on a link edge cycle must not be lost
               if (rx_take) begin
                  state <= ST_IDLE;
               end
            end
            ST_TX: begin
               if (tx_abandon) begin
                  state <= ST_RX;
                  bit_cnt <= BIT_CNT_ZERO;
               end else begin
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == BIT_CNT_LAST) begin
                     state <= ST_IDLE;
                  end
               end
            end
         endcase
      end else if (state == ST_HOLD && rx_take) begin
         state <= ST_IDLE;
      end
   end

   // route received byte, with fallback when target not in fast serial mode
   logic route_b;
   assign route_b = (rx_target_channel_bit == CHAN_B) ? fast_b : ~fast_a;
   // data bits sit just below the target bit; the lowest stage is unused
   assign rx_data = shreg[DATA_W:1];
   assign rx_take = rx_a_valid & rx_a_ready | rx_b_valid & rx_b_ready;
   assign rx_a_valid = (state == ST_HOLD) & ~route_b;
   assign rx_b_valid = (state == ST_HOLD) & route_b;

   // transmit byte taken after its last data bit goes out
   logic tx_done;
   assign tx_done = sclk_rise & (state == ST_TX) & (bit_cnt == BIT_CNT_LAST);

   // partner start arrives just as our start bit is due: back off and receive
   assign tx_abandon = (state == ST_TX) & (bit_cnt == BIT_CNT_ZERO)
                       & (sdi == START_LEVEL);
   assign tx_a_ready = tx_done & (tx_sel == CHAN_A);
   assign tx_b_ready = tx_done & (tx_sel == CHAN_B);

   function automatic logic frame_bit(input logic [3:0] idx, input logic [DATA_W-1:0] d,
                                      input logic src);
      if (idx == BIT_CNT_ZERO) begin
         frame_bit = START_LEVEL;
      end else if (idx == BIT_CNT_LAST) begin
         frame_bit = src;
      end else begin
         frame_bit = d[idx[2:0] - 3'h1];
      end
   endfunction : frame_bit

   always_ff @(posedge clk) begin
      if (!resetn || !active) begin
         out_bit <= IDLE_LEVEL;
      end else if (sclk_rise) begin
         if (state == ST_TX && !tx_abandon) begin
            out_bit <= frame_bit(bit_cnt, (tx_sel == CHAN_B) ? tx_b_data : tx_a_data,
                                 tx_sel);
         end else begin
            out_bit <= IDLE_LEVEL;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn || !active) begin
         cts <= 1'b0;
      end else if (sclk_rise) begin
         cts <= ((state == ST_IDLE) | (state == ST_TX)) & (sdi != START_LEVEL);
      end
   end

   assign link.serial_out_line = out_bit;
   assign link.clear_to_send_out = cts;
endmodule : fsp_device

/* File: fsp_edge_sync.sv */
`timescale 1ns/1ns
module fsp_edge_sync (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // asynchronous input
   input wire logic async_in,
   // synchronised level and edges
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta;
   logic sync;
   logic prev;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta <= 1'b1;
         sync <= 1'b1;
         prev <= 1'b1;
      end else begin
         meta <= async_in;
         sync <= meta;
         prev <= sync;
      end
   end

   assign level = sync;
   assign rise = sync & ~prev;
   assign fall = ~sync & prev;
endmodule : fsp_edge_sync

/* File: fsp_link_if.sv */
`timescale 1ns/1ns
interface fsp_link_if;
   logic serial_in_line;
   logic external_shift_clock;
   logic serial_out_line;
   logic clear_to_send_out;
   modport device (
      input serial_in_line,
      input external_shift_clock,
      output serial_out_line,
      output clear_to_send_out
   );
   modport partner (
      output serial_in_line,
      output external_shift_clock,
      input serial_out_line,
      input clear_to_send_out
   );
endinterface : fsp_link_if

/* File: fsp_link_properties.sv */
`timescale 1ns/1ns
module fsp_link_properties (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // link wires
   input wire logic serial_in_line,
   input wire logic external_shift_clock,
   input wire logic serial_out_line,
   input wire logic clear_to_send_out
);
   logic sq;
   logic [3:0] rxc;
   logic [3:0] txc;
   logic [3:0] age;
   wire rise = external_shift_clock & ~sq;
   wire fall = ~external_shift_clock & sq;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   always_ff @(posedge clk) begin
      sq <= external_shift_clock;
   end
   // cycles since the last link rise, saturating
   always_ff @(posedge clk) begin
      if (!resetn) age <= 4'hF;
      else if (rise) age <= 4'h0;
      else if (age != 4'hF) age <= age + 4'h1;
   end
   always_ff @(posedge clk) begin
      if (!resetn) rxc <= 4'h0;
      else if (rise && (rxc != 4'h0 || !serial_in_line)) rxc <= (rxc == 4'h9) ? 4'h0 : rxc + 4'h1;
   end
   // an incoming frame past its start cancels any outgoing count
   always_ff @(posedge clk) begin
      if (!resetn || rxc > 4'h1) txc <= 4'h0;
      else if (fall && (txc != 4'h0 || !serial_out_line)) txc <= (txc == 4'h9) ? 4'h0 : txc + 4'h1;
   end
   chk_out_idle_reset: assert property ($past(!resetn) |-> serial_out_line)
      else $error("data out not idle after reset");
   chk_out_clocked: assert property ($changed(serial_out_line) |-> age <= 4'h7)
      else $error("data out moved without a link clock rise");
   chk_start_needs_cts: assert property (rise && rxc == 4'h0 && !serial_in_line |-> clear_to_send_out)
      else $error("frame started while clear to send low");
   chk_cts_drop_time: assert property (rise && rxc == 4'h1 |-> ##[1:7] !clear_to_send_out)
      else $error("clear to send not dropped after start");
   chk_cts_low_frame: assert property (rise && rxc > 4'h1 |-> !clear_to_send_out)
      else $error("clear to send high within a frame");
   chk_tx_not_rx: assert property (fall && txc == 4'h0 && !serial_out_line |-> rxc <= 4'h1)
      else $error("transmit start during receive");
   chk_out_quiet_rx: assert property (fall && rxc > 4'h1 |-> serial_out_line)
      else $error("data out active while receiving");
   chk_in_idle_reset: assert property ($past(!resetn) |-> serial_in_line && !external_shift_clock)
      else $error("partner lines not idle after reset");
   cover property (rise && rxc == 4'h9);
   cover property (fall && txc == 4'h9);
   cover property (rise && rxc == 4'h9 ##[1:400] fall && txc == 4'h1);
endmodule : fsp_link_properties

/* File: fsp_partner.sv */
`timescale 1ns/1ns
module fsp_partner
   import fsp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // link pins
   fsp_link_if.partner link,
   // bytes to send
   input wire logic send_valid,
   input wire logic [DATA_W-1:0] send_data,
   input wire logic send_target,
   output logic send_ready,
   // bytes received
   output logic recv_valid,
   output logic [DATA_W-1:0] recv_data,
   output logic recv_source,
   input wire logic recv_ready
);
   typedef enum logic [1:0] {
      P_IDLE = 2'b00,
      P_SEND = 2'b01,
      P_RECV = 2'b11,
      P_FULL = 2'b10
   } pstate_e;

   pstate_e state;
   logic sclk;
   logic [3:0] half_cnt;
   logic [3:0] bit_cnt;
   logic [FRAME_BITS-1:0] shreg;
   logic sdo;
   logic cts;
   logic din;
   logic [DATA_W-1:0] rbuf;
   logic rsrc;
   logic rvalid;
   logic edge_now;

   fsp_edge_sync u_do_sync (
      .clk(clk), .resetn(resetn), .async_in(link.serial_out_line),
      .level(sdo), .rise(), .fall()
   );
   fsp_edge_sync u_cts_sync (
      .clk(clk), .resetn(resetn), .async_in(link.clear_to_send_out),
      .level(cts), .rise(), .fall()
   );

   // clock stalls while a received byte is still unread
   always_ff @(posedge clk) begin
      if (!resetn) begin
         half_cnt <= BIT_CNT_ZERO;
         sclk <= 1'b0;
      end else if (half_cnt == HALF_CNT_LAST) begin
         half_cnt <= BIT_CNT_ZERO;
         sclk <= sclk ? 1'b0 : ~rvalid;
      end else begin
         half_cnt <= half_cnt + 4'h1;
      end
   end
   assign edge_now = (half_cnt == HALF_CNT_LAST) & sclk; // falling edge

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= P_IDLE;
         bit_cnt <= BIT_CNT_ZERO;
         shreg <= '1;
         din <= IDLE_LEVEL;
      end else if (edge_now) begin
         unique case (state)
            P_IDLE: begin
               bit_cnt <= BIT_CNT_ZERO;
               if (sdo == START_LEVEL) begin
                  state <= P_RECV;
               end else if (send_valid && cts) begin
                  state <= P_SEND;
                  din <= START_LEVEL;
                  shreg <= {IDLE_LEVEL, send_target, send_data};
               end
            end
            P_SEND: begin
               din <= shreg[0];
               shreg <= {IDLE_LEVEL, shreg[FRAME_BITS-1:1]};
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == BIT_CNT_LAST) begin
                  state <= P_IDLE;
               end
            end
            P_RECV: begin
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == BIT_CNT_LAST - 4'h1) begin
                  state <= P_IDLE;
               end
            end
            P_FULL: state <= P_IDLE;
         endcase
      end
   end
   assign send_ready = edge_now & (state == P_SEND) & (bit_cnt == BIT_CNT_LAST);

   // sample device data mid-bit, on the falling edge, once the start has been seen
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rbuf <= '0;
         rsrc <= CHAN_A;
         rvalid <= 1'b0;
      end else if (edge_now && state == P_RECV) begin
         if (bit_cnt == BIT_CNT_LAST - 4'h1) begin
            rsrc <= sdo;
            rvalid <= 1'b1;
         end else begin
            rbuf <= {sdo, rbuf[DATA_W-1:1]};
         end
      end else if (rvalid && recv_ready) begin
         rvalid <= 1'b0;
      end
   end

   assign recv_valid = rvalid;
   assign recv_data = rbuf;
   assign recv_source = rsrc;
   assign link.external_shift_clock = sclk;
   assign link.serial_in_line = din;
endmodule : fsp_partner

/* File: fsp_pkg.sv */
package fsp_pkg;
   localparam int DATA_W = 8;
   localparam int FRAME_BITS = 10;
   localparam logic [3:0] BIT_CNT_LAST = 4'h9;
   localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
   localparam logic [7:0] MODE_FREEZE = 8'h10;
   localparam logic [7:0] MODE_RELEASE = 8'h00;
   localparam logic CHAN_A = 1'h0;
   localparam logic CHAN_B = 1'h1;
   localparam logic START_LEVEL = 1'h0;
   localparam logic IDLE_LEVEL = 1'h1;
   localparam int CLK_PERIOD_NS = 10;
   localparam int LINK_HALF_NS = 80;
   localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] HALF_CNT_LAST = 4'(LINK_HALF_CYC - 1);
endpackage : fsp_pkg

/* File: tb.sv */
`timescale 1ns/1ns
module tb;
   import fsp_pkg::*;
   logic clk, resetn, cfg_fast_a, cfg_fast_b, mode_valid;
   logic [7:0] mode_value, tx_a_data, tx_b_data, rx_data, send_data, recv_data;
   logic port_enabled, chan_b_pins_serial, chan_a_serial;
   logic tx_a_valid, tx_b_valid, tx_a_ready, tx_b_ready;
   logic rx_a_valid, rx_b_valid, rx_a_ready, rx_b_ready;
   logic send_valid, send_target, send_ready, recv_valid, recv_source, recv_ready;
   int errors, checks;
   logic [31:0] seed;
   logic sq;
   logic [3:0] ic, oc;
   logic [9:0] ib, ob;
   logic [9:0] in_q[$];
   logic [9:0] out_q[$];
   fsp_link_if link_inst ();
   wire sclk = link_inst.external_shift_clock;
   wire din = link_inst.serial_in_line;
   wire dout = link_inst.serial_out_line;
   fsp_device fsp_device_inst (.clk(clk), .resetn(resetn), .link(link_inst),
      .cfg_fast_a(cfg_fast_a), .cfg_fast_b(cfg_fast_b), .mode_valid(mode_valid),
      .mode_value(mode_value), .port_enabled(port_enabled),
      .chan_b_pins_serial(chan_b_pins_serial), .chan_a_serial(chan_a_serial),
      .tx_a_valid(tx_a_valid), .tx_a_data(tx_a_data), .tx_a_ready(tx_a_ready),
      .tx_b_valid(tx_b_valid), .tx_b_data(tx_b_data), .tx_b_ready(tx_b_ready),
      .rx_a_valid(rx_a_valid), .rx_b_valid(rx_b_valid), .rx_data(rx_data),
      .rx_a_ready(rx_a_ready), .rx_b_ready(rx_b_ready));
   fsp_partner fsp_partner_inst (.clk(clk), .resetn(resetn), .link(link_inst),
      .send_valid(send_valid), .send_data(send_data), .send_target(send_target),
      .send_ready(send_ready), .recv_valid(recv_valid), .recv_data(recv_data),
      .recv_source(recv_source), .recv_ready(recv_ready));
   fsp_link_properties fsp_link_properties_inst (.clk(clk), .resetn(resetn),
      .serial_in_line(link_inst.serial_in_line), .external_shift_clock(sclk),
      .serial_out_line(dout), .clear_to_send_out(link_inst.clear_to_send_out));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // wire monitor: frames captured bit by bit, start bit in bit 0
   always @(posedge clk) begin
      sq <= sclk;
      if (sclk && !sq && (ic != 4'h0 || !din)) begin
         ib = {din, ib[9:1]};
         ic <= (ic == 4'h9) ? 4'h0 : ic + 4'h1;
         if (ic == 4'h9) in_q.push_back(ib);
      end
      if (ic > 4'h1) oc <= 4'h0;
      else if (!sclk && sq && (oc != 4'h0 || !dout)) begin
         ob = {dout, ob[9:1]};
         oc <= (oc == 4'h9) ? 4'h0 : oc + 4'h1;
         if (oc == 4'h9) out_q.push_back(ob);
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic exp_route(input logic tgt);
      return (tgt == CHAN_A && cfg_fast_a && cfg_fast_b) ? CHAN_A : CHAN_B;
   endfunction : exp_route
   function automatic logic [9:0] exp_frame(input logic ch, input logic [7:0] d);
      return {ch, d, START_LEVEL};
   endfunction : exp_frame
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick
   task automatic cmp_bit(input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : cmp_bit
   task automatic cmp_word(input logic [9:0] exp, input logic [9:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : cmp_word
   task automatic dev_tx(input logic ch, input logic [7:0] d);
      int k;
      tx_a_data = d;
      tx_b_data = d;
      tx_a_valid = !ch;
      tx_b_valid = ch;
      for (k = 0; k < 3000 && (tx_a_ready | tx_b_ready) !== 1'b1; k++) tick(1);
      tick(1);
      tx_a_valid = 1'b0;
      tx_b_valid = 1'b0;
      for (k = 0; k < 3000 && recv_valid !== 1'b1; k++) tick(1);
      cmp_word({2'h0, d}, {2'h0, recv_data});
      cmp_bit(ch, recv_source);
      tick(int'(seed[6:0]) + 9);
      cmp_bit(1'b0, sclk);
      recv_ready = 1'b1;
      tick(1);
      recv_ready = 1'b0;
      cmp_word(exp_frame(ch, d), (out_q.size() != 0) ? out_q.pop_front() : 10'h3FF);
   endtask : dev_tx
   task automatic part_tx(input logic tgt, input logic [7:0] d);
      int k;
      logic ch;
      ch = exp_route(tgt);
      send_data = d;
      send_target = tgt;
      send_valid = 1'b1;
      for (k = 0; k < 3000 && send_ready !== 1'b1; k++) tick(1);
      tick(1);
      send_valid = 1'b0;
      for (k = 0; k < 3000 && (rx_a_valid | rx_b_valid) !== 1'b1; k++) tick(1);
      cmp_bit(ch, rx_b_valid);
      cmp_bit(!ch, rx_a_valid);
      cmp_word({2'h0, d}, {2'h0, rx_data});
      // slow consumer keeps clear to send low meanwhile
      tick(int'(seed[6:0]));
      rx_a_ready = !ch;
      rx_b_ready = ch;
      tick(1);
      rx_a_ready = 1'b0;
      rx_b_ready = 1'b0;
      cmp_word(exp_frame(tgt, d), (in_q.size() != 0) ? in_q.pop_front() : 10'h3FF);
   endtask : part_tx
   task automatic set_mode(input logic [7:0] v);
      mode_value = v;
      mode_valid = 1'b1;
      tick(1);
      mode_valid = 1'b0;
      tick(1);
   endtask : set_mode
   task automatic test_done;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   initial begin
      #600000;
      errors++;
      test_done;
   end
   initial begin
      {resetn, cfg_fast_a, cfg_fast_b, mode_valid, mode_value} = 12'h600;
      {tx_a_valid, tx_b_valid, tx_a_data, tx_b_data, rx_a_ready, rx_b_ready} = 20'h0;
      {send_valid, send_data, send_target, recv_ready} = 11'h0;
      {errors, checks, seed, sq, ic, oc} = {32'h0, 32'h0, 32'h7E53F9AF, 9'h0};
      tick(5);
      resetn = 1'b1;
      tick(2);
      for (int i = 0; i < 4; i++) begin
         {cfg_fast_a, cfg_fast_b} = 2'(i);
         tick(2);
         cmp_bit(i[0], port_enabled);
         cmp_bit(i[0], chan_b_pins_serial);
         cmp_bit(i[0] & i[1], chan_a_serial);
      end
      dev_tx(CHAN_B, 8'h00);
      part_tx(CHAN_A, 8'hFF);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         dev_tx(seed[8], seed[7:0]);
         seed = lfsr(seed);
         part_tx(seed[8], seed[7:0]);
      end
      cfg_fast_a = 1'b0;
      tick(2);
      part_tx(CHAN_A, 8'h5A);
      cfg_fast_a = 1'b1;
      fork
         dev_tx(CHAN_B, 8'h3C);
         part_tx(CHAN_B, 8'hC3);
      join
      set_mode(MODE_FREEZE);
      fork
         part_tx(CHAN_B, 8'hA5);
         begin
            tick(400);
            cmp_bit(1'b0, rx_b_valid);
            cmp_bit(1'b0, link_inst.clear_to_send_out);
            set_mode(MODE_RELEASE);
         end
      join
      test_done;
   end
endmodule : tb
